// file: src/spm_pkg.sv
// Package for the byte-wide SPI master/slave port: register map, field
// positions, reset values, clock divider table, state and carrier types.
// Assumes a processor register port with separate data and I/O spaces.
package spm_pkg;
   // Data-space offsets; I/O space sits this far below
   localparam logic [7:0] SPM_OFF_CONTROL = 8'h4C;
   localparam logic [7:0] SPM_OFF_STATUS = 8'h4D;
   localparam logic [7:0] SPM_OFF_DATA = 8'h4E;
   localparam logic [7:0] SPM_IO_SHIFT = 8'h20;
   // Reset values
   localparam logic [7:0] SPM_CONTROL_RST = 8'h00;
   localparam logic [7:0] SPM_DATA_RST = 8'h00;
   // Status field positions
   localparam int SPM_ST_COMPLETE = 7;
   localparam int SPM_ST_COLLISION = 6;
   localparam int SPM_ST_DOUBLE = 0;
   // Half serial clock periods in system clocks, indexed {double, rate}
   localparam logic [6:0] SPM_HALF_N0 = 7'h02;
   localparam logic [6:0] SPM_HALF_N1 = 7'h08;
   localparam logic [6:0] SPM_HALF_N2 = 7'h20;
   localparam logic [6:0] SPM_HALF_N3 = 7'h40;
   localparam logic [6:0] SPM_HALF_D0 = 7'h01;
   localparam logic [6:0] SPM_HALF_D1 = 7'h04;
   localparam logic [6:0] SPM_HALF_D2 = 7'h10;
   localparam logic [6:0] SPM_HALF_D3 = 7'h20;
   // Sixteen clock edges make one byte
   localparam logic [3:0] SPM_LAST_EDGE = 4'hF;

   // Control register layout, bit 7 first
   typedef struct packed {
      logic transfer_irq_enable;
      logic port_enable;
      logic bit_order;
      logic master_select;
      logic clock_polarity;
      logic clock_phase;
      logic rate_code_high;
      logic rate_code_low;
   } spm_ctrl_s;

   // One processor register access
   typedef struct packed {
      logic [7:0] addr;
      logic io_space;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } spm_bus_s;

   // Master clock generator state
   typedef enum logic {SPM_IDLE, SPM_RUN} spm_state_e;
endpackage : spm_pkg

// file: src/spm_port.sv
// SPI port core: register file, master clock generator, shared shifter.
// Assumes one processor access per cycle and pins driven through an
// external pad ring that resolves the output enables.
`timescale 1ns/1ps
`default_nettype none
module spm_port
   import spm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire spm_bus_s bus, // Processor register access
   input wire logic vector_ack, // Interrupt vector being executed
   input wire logic global_irq_enable, // Global enable from cpu_status_word
   input wire logic ss_is_input, // Select pin configured as input
   input wire logic ss_n_in, // Select pin level, active low
   input wire logic sck_in,
   input wire logic mosi_in,
   input wire logic miso_in,
   output logic [7:0] rdata,
   output logic irq,
   output logic sck_out,
   output logic sck_oe,
   output logic mosi_out,
   output logic mosi_oe,
   output logic miso_out,
   output logic miso_oe
);
   // Address match in either data or I/O instruction space
   function automatic logic hit(input spm_bus_s b, input logic [7:0] off);
      hit = b.io_space ? (b.addr == (off - SPM_IO_SHIFT)) : (b.addr == off);
   endfunction : hit

   // Next outgoing bit of the shifter
   function automatic logic pick(input logic [7:0] s, input logic lsb_first);
      pick = lsb_first ? s[0] : s[7];
   endfunction : pick

   // Shift one received bit in, opposite end from the outgoing bit
   function automatic logic [7:0] shift_in(input logic [7:0] s, input logic lsb_first, input logic b);
      shift_in = lsb_first ? {b, s[7:1]} : {s[6:0], b};
   endfunction : shift_in

   spm_ctrl_s ctrl_r; // Control register
   logic complete_r; // Transfer complete flag
   logic collision_r; // Write collision flag
   logic double_r; // Double speed bit
   logic armed_r; // Status was read with a flag up
   logic [7:0] sr_r; // Shift register
   logic [7:0] sr_nxt, mrx_nxt;
   logic [7:0] rx_buf_r; // Receive buffer seen by reads
   logic [7:0] mrx_r; // Master receive shifter, fed by late samples
   logic [2:0] msamp_d_r, mdone_d_r; // Master sample and end strobes, delayed
   logic [7:0] rdata_r;
   logic irq_r;
   spm_state_e st_r;
   logic [6:0] div_r; // Half-period counter
   logic [6:0] half; // Selected half period
   logic [3:0] edge_r; // Edge index within byte
   logic tx_bit_r; // Outgoing data bit, feeds both data pins
   logic sck_r;
   logic sck_oe_r, mosi_oe_r, miso_oe_r;
   // Two-flop synchronisers; the first stage feeds only the second
   logic ss_m_r, ss_s_r;
   logic sck_m_r, sck_s_r, sck_d_r;
   logic mosi_m_r, mosi_s_r;
   logic miso_m_r, miso_s_r;

   logic ctrl_wr, status_wr, status_rd, data_wr, data_acc;
   logic en, master, slave_act, busy, fault;
   logic m_edge, s_edge, edge_p, lead, sample_p, setup_p, done_p, start_p, fin_p;
   logic in_bit;

   // Register access decode
   always_comb
   begin
      ctrl_wr = bus.wr && hit(bus, SPM_OFF_CONTROL);
      status_wr = bus.wr && hit(bus, SPM_OFF_STATUS);
      status_rd = bus.rd && hit(bus, SPM_OFF_STATUS);
      data_wr = bus.wr && hit(bus, SPM_OFF_DATA);
      data_acc = (bus.wr || bus.rd) && hit(bus, SPM_OFF_DATA);
   end

   // Mode and divider selection
   always_comb
   begin
      en = ctrl_r.port_enable;
      master = en && ctrl_r.master_select;
      slave_act = en && !ctrl_r.master_select && !ss_s_r;
      fault = master && ss_is_input && !ss_s_r;
      busy = (st_r == SPM_RUN) || (mdone_d_r != 3'h0) || (slave_act && (edge_r != 4'h0));
      // Rate bits only steer the master generator
      case ({double_r, ctrl_r.rate_code_high, ctrl_r.rate_code_low})
         3'h0: half = SPM_HALF_N0;
         3'h1: half = SPM_HALF_N1;
         3'h2: half = SPM_HALF_N2;
         3'h3: half = SPM_HALF_N3;
         3'h4: half = SPM_HALF_D0;
         3'h5: half = SPM_HALF_D1;
         3'h6: half = SPM_HALF_D2;
         default: half = SPM_HALF_D3;
      endcase
   end

   // Clock edge events, from generator or from synchronised pin
   always_comb
   begin
      m_edge = (st_r == SPM_RUN) && (div_r == (half - 7'h01));
      s_edge = slave_act && (sck_s_r ^ sck_d_r);
      edge_p = master ? m_edge : s_edge;
      lead = !edge_r[0];
      sample_p = edge_p && (lead ^ ctrl_r.clock_phase);
      setup_p = edge_p && !(lead ^ ctrl_r.clock_phase);
      done_p = edge_p && (edge_r == SPM_LAST_EDGE);
      start_p = data_wr && master && !fault && !busy;
      in_bit = master ? miso_s_r : mosi_s_r;
      sr_nxt = sample_p ? shift_in(sr_r, ctrl_r.bit_order, in_bit) : sr_r;
      mrx_nxt = msamp_d_r[2] ? shift_in(mrx_r, ctrl_r.bit_order, miso_s_r) : mrx_r;
      fin_p = (done_p && !master) || mdone_d_r[2];
   end

   // Pin synchronisers; master samples wait three cycles so the data pin's synchroniser catches up at fastest rate
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ss_m_r <= 1'b1;
         ss_s_r <= 1'b1;
         sck_m_r <= 1'b0;
         sck_s_r <= 1'b0;
         sck_d_r <= 1'b0;
         mosi_m_r <= 1'b0;
         mosi_s_r <= 1'b0;
         miso_m_r <= 1'b0;
         miso_s_r <= 1'b0;
         msamp_d_r <= 3'h0;
         mdone_d_r <= 3'h0;
         mrx_r <= SPM_DATA_RST;
      end
      else
      begin
         ss_m_r <= ss_n_in;
         ss_s_r <= ss_m_r;
         sck_m_r <= sck_in;
         sck_s_r <= sck_m_r;
         sck_d_r <= sck_s_r; // Edge detector looks at stage two and three
         mosi_m_r <= mosi_in;
         mosi_s_r <= mosi_m_r;
         miso_m_r <= miso_in;
         miso_s_r <= miso_m_r;
         msamp_d_r <= {msamp_d_r[1:0], sample_p && master};
         mdone_d_r <= {mdone_d_r[1:0], done_p && master};
         mrx_r <= mrx_nxt;
      end
   end

   // Control register; hardware drop of master mode beats a write
   always_ff @(posedge clk)
   begin
      if (rst)
         ctrl_r <= SPM_CONTROL_RST;
      else
      begin
         if (ctrl_wr)
            ctrl_r <= bus.wdata;
         if (fault)
            ctrl_r.master_select <= 1'b0;
      end
   end

   // Double speed bit; other status bits are not writable
   always_ff @(posedge clk)
   begin
      if (rst)
         double_r <= 1'b0;
      else if (status_wr)
         double_r <= bus.wdata[SPM_ST_DOUBLE];
   end

   // Arm flag clearing on a status read that saw a flag up
   always_ff @(posedge clk)
   begin
      if (rst)
         armed_r <= 1'b0;
      else if (status_rd)
         armed_r <= complete_r || collision_r;
      else if (data_acc)
         armed_r <= 1'b0;
   end

   // Transfer complete flag; a new event wins over any clear
   always_ff @(posedge clk)
   begin
      if (rst)
         complete_r <= 1'b0;
      else if (fin_p || fault)
         complete_r <= 1'b1;
      else if (vector_ack)
         complete_r <= 1'b0;
      else if (data_acc && armed_r)
         complete_r <= 1'b0;
   end

   // Write collision flag
   always_ff @(posedge clk)
   begin
      if (rst)
         collision_r <= 1'b0;
      else if (data_wr && busy)
         collision_r <= 1'b1;
      else if (data_acc && armed_r)
         collision_r <= 1'b0;
   end

   // Interrupt request, registered
   always_ff @(posedge clk)
   begin
      if (rst)
         irq_r <= 1'b0;
      else
         irq_r <= ctrl_r.transfer_irq_enable && complete_r && global_irq_enable;
   end

   // Master clock generator state
   always_ff @(posedge clk)
   begin
      if (rst)
         st_r <= SPM_IDLE;
      else if (!master || fault)
         st_r <= SPM_IDLE; // Losing master mode aborts the byte
      else if (start_p)
         st_r <= SPM_RUN;
      else if (m_edge && (edge_r == SPM_LAST_EDGE))
         st_r <= SPM_IDLE;
   end

   // Half-period divider
   always_ff @(posedge clk)
   begin
      if (rst)
         div_r <= 7'h00;
      else if ((st_r != SPM_RUN) || m_edge)
         div_r <= 7'h00;
      else
         div_r <= div_r + 7'h01;
   end

   // Edge index; a deselected slave starts over
   always_ff @(posedge clk)
   begin
      if (rst)
         edge_r <= 4'h0;
      else if (start_p || (!master && !slave_act))
         edge_r <= 4'h0;
      else if (edge_p)
         edge_r <= edge_r + 4'h1;
   end

   // Shift register: loaded by an accepted write, shifted on sample edges
   always_ff @(posedge clk)
   begin
      if (rst)
         sr_r <= SPM_DATA_RST;
      else if (data_wr && !busy)
         sr_r <= bus.wdata;
      else
         sr_r <= sr_nxt;
   end

   // Receive buffer keeps the last complete byte only
   always_ff @(posedge clk)
   begin
      if (rst)
         rx_buf_r <= SPM_DATA_RST;
      else if (fin_p)
         rx_buf_r <= mdone_d_r[2] ? mrx_nxt : sr_nxt;
   end

   // Outgoing bit: preset at master start in either phase, and for the slave before the first edge when phase is zero
   always_ff @(posedge clk)
   begin
      if (rst)
         tx_bit_r <= 1'b0;
      else if (start_p)
         tx_bit_r <= pick(bus.wdata, ctrl_r.bit_order);
      else if (setup_p)
         tx_bit_r <= pick(sr_r, ctrl_r.bit_order);
      else if (!master && !ctrl_r.clock_phase && (edge_r == 4'h0))
         tx_bit_r <= pick(sr_r, ctrl_r.bit_order);
   end

   // Serial clock output, idling at the polarity level
   always_ff @(posedge clk)
   begin
      if (rst)
         sck_r <= 1'b0;
      else if (st_r != SPM_RUN)
         sck_r <= ctrl_r.clock_polarity;
      else if (m_edge)
         sck_r <= !sck_r;
   end

   // Pin directions: master drives clock and data out, selected slave its output
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sck_oe_r <= 1'b0;
         mosi_oe_r <= 1'b0;
         miso_oe_r <= 1'b0;
      end
      else
      begin
         sck_oe_r <= master && !fault;
         mosi_oe_r <= master && !fault;
         miso_oe_r <= slave_act;
      end
   end

   // Read data, registered one cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (rst)
         rdata_r <= 8'h00;
      else if (bus.rd && hit(bus, SPM_OFF_CONTROL))
         rdata_r <= ctrl_r;
      else if (status_rd)
         rdata_r <= {complete_r, collision_r, 5'h00, double_r};
      else if (bus.rd && hit(bus, SPM_OFF_DATA))
         rdata_r <= rx_buf_r;
      else
         rdata_r <= 8'h00;
   end

   assign rdata = rdata_r;
   assign irq = irq_r;
   assign sck_out = sck_r;
   assign sck_oe = sck_oe_r;
   assign mosi_out = tx_bit_r;
   assign mosi_oe = mosi_oe_r;
   assign miso_out = tx_bit_r;
   assign miso_oe = miso_oe_r;
endmodule : spm_port
`default_nettype wire

// file: tb/spm_port_assertions.sv
// Checker for the SPI port: register read path, pin enables and interrupt.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module spm_port_assertions
   import spm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire spm_bus_s bus,
   input wire logic vector_ack,
   input wire logic global_irq_enable,
   input wire logic ss_is_input,
   input wire logic ss_n_in,
   input wire logic [7:0] rdata,
   input wire logic irq,
   input wire logic sck_oe,
   input wire logic mosi_oe,
   input wire logic miso_oe
);
   logic [7:0] eff; // Access address moved into data space
   logic hit; // Access lands on one of the three registers
   logic [2:0] ss_hi_cnt_r; // Cycles the select pin has stood high
   logic [2:0] fault_cnt_r; // Cycles a mode fault has stood
   assign eff = bus.addr + (bus.io_space ? SPM_IO_SHIFT : 8'h00);
   assign hit = (eff >= SPM_OFF_CONTROL) && (eff <= SPM_OFF_DATA);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Saturates, so a long deselect needs only three bits
   always_ff @(posedge clk)
   begin
      if (rst || !ss_n_in)
         ss_hi_cnt_r <= 3'h0;
      else if (ss_hi_cnt_r != 3'h7)
         ss_hi_cnt_r <= ss_hi_cnt_r + 3'h1;
   end
   // Mode fault duration, saturating
   always_ff @(posedge clk)
   begin
      if (rst || !ss_is_input || ss_n_in)
         fault_cnt_r <= 3'h0;
      else if (fault_cnt_r != 3'h7)
         fault_cnt_r <= fault_cnt_r + 3'h1;
   end
   a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
      else $error("read data not zero without a read");
   a_unmapped_zero: assert property ($past(bus.rd) && !$past(hit) |-> rdata == 8'h00)
      else $error("unmapped read returned data");
   a_status_unused: assert property ($past(bus.rd) && $past(eff) == SPM_OFF_STATUS |-> rdata[5:1] == 5'h00)
      else $error("unused status bits not zero");
   a_oe_exclusive: assert property (!(sck_oe && miso_oe))
      else $error("clock and slave output driven together");
   a_mosi_with_sck: assert property (mosi_oe == sck_oe)
      else $error("master data and clock enables differ");
   a_slave_float: assert property (ss_hi_cnt_r == 3'h7 |-> !miso_oe)
      else $error("deselected slave drives its output");
   a_fault_drops: assert property (fault_cnt_r == 3'h7 |-> !sck_oe)
      else $error("clock still driven after mode fault");
   a_irq_drop: assert property (!global_irq_enable |=> !irq)
      else $error("interrupt without global enable");
   a_vector_clears: assert property (vector_ack |-> ##2 !irq)
      else $error("interrupt stays after vector");
endmodule : spm_port_assertions
bind spm_port spm_port_assertions chk (.clk, .rst, .bus, .vector_ack, .global_irq_enable,
   .ss_is_input, .ss_n_in, .rdata, .irq, .sck_oe, .mosi_oe, .miso_oe);
`default_nettype wire

// file: tb/spm_slave_model.sv
// Behavioural SPI slave that faces the port while it is master.
// Assumes the bench drives its select, mode and transmit byte.
`timescale 1ns/1ps
`default_nettype none
module spm_slave_model
(
   input wire logic sck,
   input wire logic mosi,
   input wire logic cs_n,
   input wire logic samp_rise, // Sample edge is the rising one
   input wire logic cpha,
   input wire logic lsb,
   input wire logic [7:0] tx,
   output logic miso,
   output logic [7:0] rx
);
   int no; // Bits presented so far
   int ni; // Bits captured so far
   initial miso = 1'b0;
   // Select edges restart counts; a released line keeps no stale value
   always @(cs_n)
   begin
      no = 0;
      ni = 0;
      if (cs_n)
         miso = ~miso;
      else if (!cpha)
      begin
         miso = lsb ? tx[0] : tx[7]; // Phase 0 presents before first edge
         no = 1;
      end
   end
   // Capture on the sample edge, change on the other one
   always @(sck)
   begin
      if (!cs_n && (sck == samp_rise) && ni < 8)
      begin
         rx[lsb ? ni : 7 - ni] = mosi;
         ni++;
      end
      else if (!cs_n && (sck != samp_rise) && no < 8)
      begin
         miso = lsb ? tx[no] : tx[7 - no];
         no++;
      end
   end
endmodule : spm_slave_model
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the SPI port with a slave model on its pins.
// Assumes the package register map and the designer's read latency.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import spm_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   spm_bus_s bus = '0;
   logic vector_ack = 1'b0;
   logic global_irq_enable = 1'b0;
   logic ss_is_input = 1'b0;
   logic ss_n_in = 1'b1;
   logic sck_in = 1'b0;
   logic mosi_in = 1'b0;
   logic miso_in, irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
   logic [7:0] rdata, ptx, prx, got;
   logic cs_n = 1'b1; // Far side select, owned by software
   spm_ctrl_s ctl = '0; // Control value last written by xfer
   logic [7:0] seed = 8'h52; // Random source
   logic rd_seen = 1'b0;
   logic [7:0] expq[$]; // Expected read data, oldest first
   int half[8] = '{2, 8, 32, 64, 1, 4, 16, 32}; // Half periods by {double, rate}
   int bad_count = 0;
   int checks_done = 0;
   int cycles = 0;
   always #2 clk = ~clk;
   spm_port uut (.clk(clk), .rst(rst), .bus(bus), .vector_ack(vector_ack),
      .global_irq_enable(global_irq_enable), .ss_is_input(ss_is_input), .ss_n_in(ss_n_in),
      .sck_in(sck_in), .mosi_in(mosi_in), .miso_in(miso_in), .rdata(rdata), .irq(irq),
      .sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
      .miso_out(miso_out), .miso_oe(miso_oe));
   spm_slave_model peer (.sck(sck_out), .mosi(mosi_out), .cs_n(cs_n),
      .samp_rise(ctl.clock_polarity == ctl.clock_phase), .cpha(ctl.clock_phase),
      .lsb(ctl.bit_order), .tx(ptx), .miso(miso_in), .rx(prx));
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next
   task automatic cmp(input logic [7:0] exp, input logic [7:0] act);
      checks_done++;
      if (act !== exp)
      begin
         bad_count++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, act);
      end
   endtask : cmp
   task automatic tally_and_finish;
      $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   // One register access; the address space is picked at random
   task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge clk);
      seed = lfsr_next(seed);
      bus <= '{addr: a - (seed[0] ? SPM_IO_SHIFT : 8'h00), io_space: seed[0], wr: w, rd: !w, wdata: d};
      @(posedge clk);
      bus <= '0;
   endtask : acc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc(a, 1'b1, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expq.push_back(e);
      acc(a, 1'b0, 8'h00);
   endtask : rd
   // Master byte; every mode, order and rate is reached through i
   task automatic xfer(input int i);
      logic [7:0] d;
      logic [7:0] st;
      logic coll;
      coll = (i == 1) || (i == 6);
      st = {7'h00, i[2]};
      wr(SPM_OFF_STATUS, st);
      ctl = {i[0], 1'b1, i[2], 1'b1, i[1], i[0], i[1], i[0]};
      global_irq_enable <= i[1];
      wr(SPM_OFF_CONTROL, ctl);
      rd(SPM_OFF_CONTROL, ctl);
      cmp({7'h00, sck_out}, {7'h00, ctl.clock_polarity});
      seed = lfsr_next(seed);
      ptx = seed;
      seed = lfsr_next(seed);
      d = seed;
      cs_n = 1'b0;
      wr(SPM_OFF_DATA, d);
      if (coll)
         wr(SPM_OFF_DATA, ~d);
      repeat (16 * half[i] - 6 - 2 * coll) @(posedge clk);
      rd(SPM_OFF_STATUS, {1'b0, coll, 5'h00, i[2]});
      repeat (8) @(posedge clk);
      rd(SPM_OFF_STATUS, {1'b1, coll, 5'h00, i[2]});
      cmp({7'h00, irq}, {7'h00, i[0] & i[1]});
      cmp(prx, d);
      cmp({6'h00, sck_oe, sck_out}, {6'h00, 1'b1, ctl.clock_polarity});
      if (i == 4)
      begin
         vector_ack <= 1'b1;
         @(posedge clk);
         vector_ack <= 1'b0;
         rd(SPM_OFF_STATUS, st);
      end
      rd(SPM_OFF_DATA, ptx);
      rd(SPM_OFF_STATUS, st);
      cs_n = 1'b1;
   endtask : xfer
   // Bench as master of the slave port, mode 0, clock well under a quarter rate
   task automatic sbits(input logic [7:0] b, input int n);
      ss_n_in <= 1'b0;
      repeat (8) @(posedge clk);
      for (int k = 0; k < n; k++)
      begin
         mosi_in <= b[7 - k];
         repeat (6) @(posedge clk);
         got[7 - k] = miso_out;
         sck_in <= 1'b1;
         repeat (6) @(posedge clk);
         sck_in <= 1'b0;
      end
      repeat (8) @(posedge clk);
      ss_n_in <= 1'b1;
      repeat (8) @(posedge clk);
   endtask : sbits
   // Result watcher: a read answers one cycle after it is taken
   always @(posedge clk)
   begin
      if (rd_seen)
         cmp(expq.pop_front(), rdata);
      rd_seen <= bus.rd;
   end
   // Hang guard; the full sequence needs under 6000 cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         tally_and_finish();
      end
   end
   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(SPM_OFF_CONTROL, SPM_CONTROL_RST);
      rd(SPM_OFF_STATUS, 8'h00);
      rd(8'h4F, 8'h00);
      wr(SPM_OFF_STATUS, 8'hFF);
      rd(SPM_OFF_STATUS, 8'h01);
      wr(SPM_OFF_CONTROL, 8'h10);
      wr(SPM_OFF_DATA, 8'hA5);
      repeat (40) @(posedge clk);
      rd(SPM_OFF_STATUS, 8'h01);
      cmp({7'h00, sck_oe}, 8'h00);
      for (int i = 0; i < 8; i++)
         xfer(i);
      ss_is_input <= 1'b1;
      wr(SPM_OFF_CONTROL, 8'h50);
      ss_n_in <= 1'b0;
      repeat (6) @(posedge clk);
      rd(SPM_OFF_CONTROL, 8'h40);
      rd(SPM_OFF_STATUS, 8'h81);
      rd(SPM_OFF_DATA, ptx);
      ss_is_input <= 1'b0;
      ss_n_in <= 1'b1;
      wr(SPM_OFF_CONTROL, 8'h43);
      wr(SPM_OFF_DATA, 8'h3C);
      sbits(8'hFF, 3);
      rd(SPM_OFF_STATUS, 8'h01);
      wr(SPM_OFF_DATA, 8'h96);
      sbits(8'h5A, 8);
      cmp(got, 8'h96);
      cmp({7'h00, miso_oe}, 8'h00);
      rd(SPM_OFF_STATUS, 8'h81);
      rd(SPM_OFF_DATA, 8'h5A);
      repeat (4) @(posedge clk);
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
